// ### design/msc_ctrl_regs.sv
// Mode/supply, hardware control and watchdog control registers behind
// the serial slave, with soft reset, restart and overvoltage handling.
// Assumes lock bits, failure flag and restart/overtemperature events come
// from logic on clk_sys; serial pins and straps are asynchronous.
`timescale 1ns/100ps
`default_nettype none
`include "msc_defs.svh"
module msc_ctrl_regs (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic spiCsN,
    input wire logic spiSclk,
    input wire logic spiMosi,
    output logic spiMiso,
    output logic spiMisoOeN,
    input wire logic devModeStrap,
    input wire logic mainOvDetect,
    input wire logic overTempEvent,
    input wire logic restartEnter,
    input wire logic cfgLockClearable,
    input wire logic cfgLockPermanent,
    input wire logic failureFlag,
    input wire logic failPinIsFailOut,
    input wire logic mainOvFlagClr,
    input wire logic cmdFailFlagClr,
    output msc_pkg::msc_mode_t opMode,
    output logic [1:0] auxSupplyMode,
    output logic auxSupplyOn,
    output logic mainOvFlag,
    output logic ovRestartReq,
    output msc_pkg::msc_thr_t mainResetThreshold,
    output logic cmdFailFlag,
    output logic softResetPulse,
    output logic resetOutPin,
    output logic resetOutOeN,
    output logic failOutPin,
    output logic chargePumpEnable,
    output logic watchdogFailCountSelect,
    output logic [7:0] watchdogControl
);
    localparam logic [7:0] SRST_CYC = 8'(`MSC_SRST_PULSE_CYC);

    // Pin synchronisers
    logic csS, sclkS, mosiS, ovS, devS;
    msc_sync #(.WIDTH(5), .INIT(5'h10)) uSync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .asyncIn({spiCsN, spiSclk, spiMosi, mainOvDetect, devModeStrap}),
        .syncOut({csS, sclkS, mosiS, ovS, devS})
    );

    logic [`MSC_ADDR_W-1:0] rdAddr;
    logic [7:0] rdData, statusByte;
    logic frameDone, frameErr;
    logic [15:0] frameData;

    msc_spi_slave uSpi (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .csN(csS),
        .sclk(sclkS),
        .mosi(mosiS),
        .statusByte(statusByte),
        .rdData(rdData),
        .rdAddr(rdAddr),
        .miso(spiMiso),
        .misoOeN(spiMisoOeN),
        .frameDone(frameDone),
        .frameErr(frameErr),
        .frameData(frameData)
    );

    // Register state
    msc_pkg::msc_mode_t mode_q;
    logic [1:0] aux_q;
    logic ovAct_q;
    logic [1:0] thr_q;
    logic srstPin_q, foForce_q, cpEn_q, wdCnt_q;
    logic [7:0] wd_q;
    logic ovFlag_q, cmdFail_q, ovPrev_q, ovReq_q;
    logic [7:0] srstCnt_q;
    logic rstPull_q;
    logic [1:0] initCnt_q;
    logic initDone_q;

    // Frame decode
    wire [`MSC_ADDR_W-1:0] wrAddr = frameData[`MSC_ADDR_W-1:0];
    wire [7:0] wrData = frameData[15:8];
    wire isWrite = frameDone && frameData[`MSC_BIT_WRITE];
    wire wrMs = isWrite && (wrAddr == `MSC_ADDR_MODE_SUPPLY);
    wire wrHw = isWrite && (wrAddr == `MSC_ADDR_HW_CTRL0);
    wire wrWd = isWrite && (wrAddr == `MSC_ADDR_WATCHDOG_CONTROL);
    wire [1:0] newMode = wrData[`MSC_MS_MODE_HI:`MSC_MS_MODE_LO];
    wire softReset = wrMs && (newMode == 2'(msc_pkg::MODE_SOFTRST));
    wire stopToSleep = wrMs && (mode_q == msc_pkg::MODE_STOP)
        && (newMode == 2'(msc_pkg::MODE_SLEEP));
    wire stopToNormal = wrMs && (mode_q == msc_pkg::MODE_STOP)
        && (newMode == 2'(msc_pkg::MODE_NORMAL));
    wire plainMsWrite = wrMs && !softReset && !stopToSleep && !stopToNormal;
    wire ovRise = ovS && !ovPrev_q;
    wire devInitLoad = !initDone_q && (initCnt_q == `MSC_INIT_WAIT);

    // Register images for readback
    wire [7:0] msImage = {mode_q, 1'b0, aux_q, ovAct_q, thr_q};
    wire [7:0] hwImage = {1'b0, srstPin_q, foForce_q, 2'b00, cpEn_q, 1'b0, wdCnt_q};

    // Readback uses the stored value, so a write returns the old contents
    assign rdData = (rdAddr == `MSC_ADDR_MODE_SUPPLY) ? msImage :
                    (rdAddr == `MSC_ADDR_HW_CTRL0) ? hwImage :
                    (rdAddr == `MSC_ADDR_WATCHDOG_CONTROL) ? wd_q : 8'h00;
    assign statusByte = {6'h00, cmdFail_q, ovFlag_q};

    // Locked bit keeps its value while its lock is set
    function automatic logic lockedWrite(input logic cur, input logic nv, input logic lock);
        lockedWrite = lock ? cur : nv;
    endfunction

    // Mode field: reset, restart and serial writes
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mode_q <= msc_pkg::MODE_NORMAL;
        end else if (restartEnter) begin
            mode_q <= msc_pkg::MODE_NORMAL;
        end else if (softReset) begin
            mode_q <= msc_pkg::MODE_NORMAL;
        end else if (stopToNormal) begin
            mode_q <= msc_pkg::MODE_NORMAL;
        end else if (plainMsWrite) begin
            mode_q <= msc_pkg::msc_mode_t'(newMode);
        end
    end

    // Remaining mode/supply fields
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            aux_q <= `MSC_AUX_OFF;
            ovAct_q <= 1'b0;
            thr_q <= 2'h0;
        end else if (restartEnter) begin
            aux_q <= `MSC_AUX_OFF;
            ovAct_q <= 1'b0;
        end else if (softReset) begin
            // Soft reset switches the aux supply off even in development mode
            aux_q <= `MSC_AUX_OFF;
            ovAct_q <= 1'b0;
            thr_q <= 2'h0;
        end else if (overTempEvent) begin
            aux_q <= `MSC_AUX_OFF;
        end else if (devInitLoad && devS) begin
            aux_q <= `MSC_AUX_ALWAYS;
        end else if (plainMsWrite) begin
            aux_q <= wrData[`MSC_MS_AUX_HI:`MSC_MS_AUX_LO];
            ovAct_q <= wrData[`MSC_MS_OVACT];
            thr_q <= wrData[`MSC_MS_THR_HI:`MSC_MS_THR_LO];
        end
    end

    // Development strap is read a few cycles after reset release
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            initCnt_q <= 2'h0;
            initDone_q <= 1'b0;
        end else if (!initDone_q) begin
            if (devInitLoad) begin
                initDone_q <= 1'b1;
            end else begin
                initCnt_q <= initCnt_q + 2'h1;
            end
        end
    end

    // Hardware control register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            srstPin_q <= 1'(`MSC_HW_RESET >> `MSC_HW_SRST_PIN);
            foForce_q <= 1'b0;
            cpEn_q <= 1'b0;
            wdCnt_q <= 1'b0;
        end else if (restartEnter) begin
            foForce_q <= 1'b0;
        end else if (softReset) begin
            srstPin_q <= lockedWrite(srstPin_q, 1'b0, cfgLockPermanent);
            cpEn_q <= lockedWrite(cpEn_q, 1'b0, cfgLockClearable);
            foForce_q <= 1'b0;
            wdCnt_q <= 1'b0;
        end else if (wrHw) begin
            srstPin_q <= lockedWrite(srstPin_q, wrData[`MSC_HW_SRST_PIN],
                cfgLockPermanent);
            cpEn_q <= lockedWrite(cpEn_q, wrData[`MSC_HW_CHARGE_PUMP_ENABLE], cfgLockClearable);
            foForce_q <= wrData[`MSC_HW_FO_FORCE];
            wdCnt_q <= wrData[`MSC_HW_WD_CNT];
        end
    end

    // Watchdog control register; reserved bit 3 always reads zero
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wd_q <= `MSC_WD_RESET;
        end else if (restartEnter) begin
            wd_q <= (wd_q & `MSC_WD_RESTART_KEEP) | `MSC_WD_RESTART_SET;
        end else if (softReset) begin
            wd_q <= `MSC_WD_RESET;
        end else if (wrWd) begin
            wd_q <= wrData & `MSC_WD_RESERVED_MASK;
        end
    end

    // Sticky flags: a set in the clearing cycle wins
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ovPrev_q <= 1'b0;
            ovFlag_q <= 1'b0;
            ovReq_q <= 1'b0;
            cmdFail_q <= 1'b0;
        end else begin
            ovPrev_q <= ovS;
            ovFlag_q <= ovRise | (ovFlag_q & ~mainOvFlagClr);
            ovReq_q <= ovRise & ovAct_q;
            cmdFail_q <= stopToNormal | stopToSleep | frameErr
                | (cmdFail_q & ~cmdFailFlagClr);
        end
    end

    // Reset output pulse for a soft reset; pin control sampled before reset
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            srstCnt_q <= 8'h00;
            rstPull_q <= 1'b0;
        end else if (softReset && !srstPin_q) begin
            srstCnt_q <= SRST_CYC;
            rstPull_q <= 1'b1;
        end else if (srstCnt_q != 8'h00) begin
            srstCnt_q <= srstCnt_q - 8'h01;
            rstPull_q <= (srstCnt_q != 8'h01);
        end
    end

    // Outputs
    logic softRstPulse_q, failOut_q, auxOn_q;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            softRstPulse_q <= 1'b0;
            failOut_q <= 1'b0;
            auxOn_q <= 1'b0;
        end else begin
            softRstPulse_q <= softReset;
            // Failure keeps the pin active after the force bit is cleared
            failOut_q <= failureFlag | (foForce_q & failPinIsFailOut);
            auxOn_q <= (aux_q == 2'h1) ? (mode_q == msc_pkg::MODE_NORMAL) :
                       (aux_q == 2'h2) ? (mode_q != msc_pkg::MODE_SLEEP) :
                       (aux_q == 2'h3);
        end
    end

    assign opMode = mode_q;
    assign auxSupplyMode = aux_q;
    assign auxSupplyOn = auxOn_q;
    assign mainOvFlag = ovFlag_q;
    assign ovRestartReq = ovReq_q;
    assign mainResetThreshold = msc_pkg::msc_thr_t'(thr_q);
    assign cmdFailFlag = cmdFail_q;
    assign softResetPulse = softRstPulse_q;
    assign resetOutPin = 1'b0;
    assign resetOutOeN = ~rstPull_q;
    assign failOutPin = failOut_q;
    assign chargePumpEnable = cpEn_q;
    assign watchdogFailCountSelect = wdCnt_q;
    assign watchdogControl = wd_q;
endmodule // msc_ctrl_regs
`default_nettype wire

// ### design/msc_defs.svh
// Offsets, field positions, reset values and timing counts for the
// mode/supply/hardware control register bank.
// Assumes a 20 MHz system clock and the 16-bit serial frame.
`ifndef MSC_DEFS_SVH
`define MSC_DEFS_SVH

`define MSC_ADDR_W 7
`define MSC_ADDR_MODE_SUPPLY 7'h01
`define MSC_ADDR_HW_CTRL0 7'h02
`define MSC_ADDR_WATCHDOG_CONTROL 7'h03

`define MSC_FRAME_BITS 5'h10
`define MSC_BIT_WRITE 7
`define MSC_BYTE_BITS 5'h08

// mode_supply_control fields
`define MSC_MS_MODE_HI 7
`define MSC_MS_MODE_LO 6
`define MSC_MS_AUX_HI 4
`define MSC_MS_AUX_LO 3
`define MSC_MS_OVACT 2
`define MSC_MS_THR_HI 1
`define MSC_MS_THR_LO 0

// hardware_control_zero fields
`define MSC_HW_SRST_PIN 6
`define MSC_HW_FO_FORCE 5
`define MSC_HW_CHARGE_PUMP_ENABLE 2
`define MSC_HW_WD_CNT 0

`define MSC_MS_RESET 8'h00
`define MSC_HW_RESET 8'h00
`define MSC_WD_RESET 8'h14
`define MSC_WD_RESERVED_MASK 8'hf7
`define MSC_WD_RESTART_KEEP 8'hb0
`define MSC_WD_RESTART_SET 8'h04
`define MSC_AUX_OFF 2'h0
`define MSC_AUX_ALWAYS 2'h3

// Low time of the reset output for a soft reset
`define MSC_CLK_MHZ 20
`define MSC_SRST_PULSE_NS 2000
`define MSC_SRST_PULSE_CYC ((`MSC_SRST_PULSE_NS * `MSC_CLK_MHZ + 999) / 1000)
`define MSC_INIT_WAIT 2'h3

`endif

// ### design/msc_pkg.sv
// Types shared by the control register bank.
// Assumes msc_defs.svh for the numeric constants.
`default_nettype none
package msc_pkg;
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_SLEEP = 2'h1,
        MODE_STOP = 2'h2,
        MODE_SOFTRST = 2'h3
    } msc_mode_t;

    typedef enum logic [1:0] {
        THR_HIGHEST = 2'h0,
        THR_SECOND = 2'h1,
        THR_THIRD = 2'h2,
        THR_FOURTH = 2'h3
    } msc_thr_t;
endpackage
`default_nettype wire

// ### design/msc_sync.sv
// Two-stage synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to clk_sys.
`timescale 1ns/100ps
`default_nettype none
module msc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            meta_q <= INIT;
            syncOut <= INIT;
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule // msc_sync
`default_nettype wire

// ### design/msc_spi_slave.sv
// Oversampled serial slave: 16-bit frames, LSB first, clock idle low,
// input sampled on rising and output shifted on falling clock edges.
// Assumes csN, sclk and mosi are already synchronised to clk_sys.
`timescale 1ns/100ps
`default_nettype none
`include "msc_defs.svh"
module msc_spi_slave (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic csN,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic [7:0] statusByte,
    input wire logic [7:0] rdData,
    output logic [`MSC_ADDR_W-1:0] rdAddr,
    output logic miso,
    output logic misoOeN,
    output logic frameDone,
    output logic frameErr,
    output logic [15:0] frameData
);
    logic sclk_q, cs_q;
    logic [4:0] bitCnt_q;
    logic [15:0] rx_q;
    logic [7:0] tx_q;
    wire sclkRise = sclk & ~sclk_q;
    wire sclkFall = ~sclk & sclk_q;
    wire csStart = ~csN & cs_q;
    wire csEnd = csN & ~cs_q;

    assign rdAddr = rx_q[`MSC_ADDR_W-1:0];

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sclk_q <= 1'b0;
            cs_q <= 1'b1;
            bitCnt_q <= 5'h00;
            rx_q <= 16'h0000;
            tx_q <= 8'h00;
            miso <= 1'b0;
            misoOeN <= 1'b1;
            frameDone <= 1'b0;
            frameErr <= 1'b0;
            frameData <= 16'h0000;
        end else begin
            sclk_q <= sclk;
            cs_q <= csN;
            misoOeN <= csN;
            frameDone <= csEnd && (bitCnt_q == `MSC_FRAME_BITS);
            frameErr <= csEnd && (bitCnt_q != `MSC_FRAME_BITS);
            if (csEnd) begin
                frameData <= rx_q;
            end
            if (csStart) begin
                bitCnt_q <= 5'h00;
                tx_q <= {1'b0, statusByte[7:1]};
                miso <= statusByte[0];
            end else if (!csN && sclkRise) begin
                if (bitCnt_q < `MSC_FRAME_BITS) begin
                    rx_q[bitCnt_q[3:0]] <= mosi;
                    bitCnt_q <= bitCnt_q + 5'h01;
                end
            end else if (!csN && sclkFall) begin
                // Old register contents go out, even on a write
                if (bitCnt_q == `MSC_BYTE_BITS) begin
                    miso <= rdData[0];
                    tx_q <= {1'b0, rdData[7:1]};
                end else begin
                    miso <= tx_q[0];
                    tx_q <= {1'b0, tx_q[7:1]};
                end
            end
        end
    end
endmodule // msc_spi_slave
`default_nettype wire

// ### dv/msc_ctrl_regs_props.sv
// Port-level assertions for the control register bank.
// Assumes one clk_sys domain with synchronous active-low rst_n.
`timescale 1ns/100ps
`default_nettype none
module msc_ctrl_regs_props (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic spiCsN,
    input wire logic spiMisoOeN,
    input wire logic mainOvDetect,
    input wire logic overTempEvent,
    input wire logic restartEnter,
    input wire logic failureFlag,
    input wire logic failPinIsFailOut,
    input wire msc_pkg::msc_mode_t opMode,
    input wire logic [1:0] auxSupplyMode,
    input wire logic auxSupplyOn,
    input wire logic mainOvFlag,
    input wire logic ovRestartReq,
    input wire msc_pkg::msc_thr_t mainResetThreshold,
    input wire logic softResetPulse,
    input wire logic resetOutOeN,
    input wire logic failOutPin,
    input wire logic [7:0] watchdogControl
);
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Counts reset-output low time so the pulse width can be judged when it ends
    logic [7:0] lowCnt_q;
    logic [7:0] lowCnt_d;
    assign lowCnt_d = resetOutOeN ? 8'h00 : lowCnt_q + 8'h01;
    always_ff @(posedge clk_sys) begin
        lowCnt_q <= rst_n ? lowCnt_d : 8'h00;
    end

    // Chip select passes two sync stages, so the enable lags it by a few cycles
    sequence oeOn;
        ##[1:5] !spiMisoOeN;
    endsequence
    sequence oeOff;
        ##[1:5] spiMisoOeN;
    endsequence
    sequence ovPulse;
        mainOvFlag ##1 !ovRestartReq;
    endsequence

    oe_on_a: assert property ($fell(spiCsN) |-> oeOn)
        else $error("serial output not enabled after select");
    oe_off_a: assert property ($rose(spiCsN) |-> oeOff)
        else $error("serial output still enabled after deselect");
    mode_legal_a: assert property (opMode != msc_pkg::MODE_SOFTRST)
        else $error("soft reset code stored as mode");
    restart_mode_a: assert property (restartEnter |=> opMode == msc_pkg::MODE_NORMAL
        && auxSupplyMode == 2'h0) else $error("restart left mode or aux supply");
    restart_thr_a: assert property (restartEnter |=> $stable(mainResetThreshold))
        else $error("restart changed reset threshold");
    overtemp_aux_a: assert property (overTempEvent |=> auxSupplyMode == 2'h0)
        else $error("overtemperature left aux supply field");
    aux_off_a: assert property (auxSupplyMode == 2'h0 |=> !auxSupplyOn)
        else $error("aux supply on with field off");
    ov_flag_a: assert property ($rose(mainOvDetect) |-> ##[1:6] mainOvFlag)
        else $error("overvoltage flag not set");
    ov_req_a: assert property (ovRestartReq |-> ovPulse)
        else $error("restart request without flag or too long");
    fail_on_a: assert property (failureFlag |=> failOutPin)
        else $error("failure did not drive fail output");
    fail_off_a: assert property (!failureFlag && !failPinIsFailOut |=> !failOutPin)
        else $error("fail output active without cause");
    srst_vals_a: assert property (softResetPulse |-> auxSupplyMode == 2'h0
        && watchdogControl == 8'h14) else $error("soft reset values wrong");
    rst_width_a: assert property ($rose(resetOutOeN) |-> lowCnt_q == 8'h28)
        else $error("reset output pulse width wrong");
    wd_rsvd_a: assert property (watchdogControl[3] == 1'b0)
        else $error("watchdog reserved bit set");
endmodule // msc_ctrl_regs_props

bind msc_ctrl_regs msc_ctrl_regs_props u_msc_ctrl_regs_props (.clk_sys, .rst_n, .spiCsN,
    .spiMisoOeN, .mainOvDetect, .overTempEvent, .restartEnter, .failureFlag,
    .failPinIsFailOut, .opMode, .auxSupplyMode, .auxSupplyOn, .mainOvFlag, .ovRestartReq,
    .mainResetThreshold, .softResetPulse, .resetOutOeN, .failOutPin, .watchdogControl);
`default_nettype wire

// ### dv/msc_host_model.sv
// Host controller model: sends 16-bit frames, LSB first, clock idle low.
// Assumes clk_sys at 50 ns; link clock half period of 4 cycles gives 200 ns.
`timescale 1ns/100ps
`default_nettype none
module msc_host_model (
    input wire logic clk_sys,
    input wire logic spiMiso,
    output logic spiCsN,
    output logic spiSclk,
    output logic spiMosi,
    output logic rxValid,
    output logic [7:0] rxByte
);
    logic [15:0] rx;
    int gapCyc = 6;
    initial begin
        spiCsN = 1'b1;
        spiSclk = 1'b0;
        spiMosi = 1'b0;
        rxValid = 1'b0;
        rxByte = 8'h00;
    end
    // Returns the byte that followed the address byte on the output line
    task automatic xfer(input logic [6:0] addr, input logic wr, input logic [7:0] data);
        logic [15:0] tx;
        tx = {data, wr, addr};
        @(negedge clk_sys) spiCsN = 1'b0;
        for (int i = 0; i < 16; i++) begin
            spiMosi = tx[i];
            repeat (4) @(negedge clk_sys);
            rx[i] = spiMiso;
            spiSclk = 1'b1;
            repeat (4) @(negedge clk_sys);
            spiSclk = 1'b0;
        end
        // Released data line must not look like a held bit
        spiMosi = ~spiMosi;
        repeat (2) @(negedge clk_sys);
        spiCsN = 1'b1;
        rxByte = rx[15:8];
        rxValid = 1'b1;
        @(negedge clk_sys) rxValid = 1'b0;
        repeat (gapCyc) @(negedge clk_sys);
    endtask
endmodule // msc_host_model
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the control register bank over the serial link.
// Assumes the host model drives the link and the checker is bound separately.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk_sys = 1'b0, rst_n = 1'b0, devModeStrap = 1'b1;
    logic spiCsN, spiSclk, spiMosi, spiMiso, spiMisoOeN, rxValid;
    logic mainOvDetect = 1'b0, overTempEvent = 1'b0, restartEnter = 1'b0;
    logic cfgLockClearable = 1'b0, cfgLockPermanent = 1'b0, failureFlag = 1'b0;
    logic failPinIsFailOut = 1'b1, mainOvFlagClr = 1'b0, cmdFailFlagClr = 1'b0;
    msc_pkg::msc_mode_t opMode;
    msc_pkg::msc_thr_t mainResetThreshold;
    logic [1:0] auxSupplyMode;
    logic auxSupplyOn, mainOvFlag, ovRestartReq, cmdFailFlag, softResetPulse, resetOutPin;
    logic resetOutOeN, failOutPin, chargePumpEnable, watchdogFailCountSelect;
    logic [7:0] watchdogControl, rxByte, old, d;
    logic [15:0] rnd = 16'hd73b;
    logic [7:0] expQ[$];
    int num_errors = 0, samples_checked = 0;

    msc_ctrl_regs u_msc_ctrl_regs (.clk_sys, .rst_n, .spiCsN, .spiSclk, .spiMosi, .spiMiso,
        .spiMisoOeN, .devModeStrap, .mainOvDetect, .overTempEvent, .restartEnter,
        .cfgLockClearable, .cfgLockPermanent, .failureFlag, .failPinIsFailOut, .mainOvFlagClr,
        .cmdFailFlagClr, .opMode, .auxSupplyMode, .auxSupplyOn, .mainOvFlag, .ovRestartReq,
        .mainResetThreshold, .cmdFailFlag, .softResetPulse, .resetOutPin, .resetOutOeN,
        .failOutPin, .chargePumpEnable, .watchdogFailCountSelect, .watchdogControl);
    msc_host_model u_msc_host_model (.clk_sys, .spiMiso, .spiCsN, .spiSclk, .spiMosi,
        .rxValid, .rxByte);

    always #25 clk_sys = ~clk_sys;

    function automatic logic [15:0] lfsrNext(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (expQ.size() != 0) num_errors++;
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        expQ.push_back(e);
        u_msc_host_model.xfer(a, 1'b0, 8'h00);
    endtask
    // The answer to a write is the content before it
    task automatic wr(input logic [6:0] a, input logic [7:0] v, input logic [7:0] e);
        expQ.push_back(e);
        u_msc_host_model.xfer(a, 1'b1, v);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk_sys) s = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic waitSig(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 200) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 200) begin
            num_errors++;
            results();
        end
    endtask

    always @(posedge clk_sys) begin
        if (rxValid) begin
            if (expQ.size() == 0) check(rxByte, ~rxByte);
            else check(rxByte, expQ.pop_front());
        end
    end

    initial begin
        repeat (5) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (8) @(negedge clk_sys);
        rd(7'h01, 8'h18);
        rd(7'h02, 8'h00);
        rd(7'h03, 8'h14);
        rd(7'h7f, 8'h00);
        $display("test reset values done");
        old = 8'h18;
        for (int i = 0; i < 4; i++) begin
            rnd = lfsrNext(rnd);
            d = {2'b00, rnd[1], 2'(i), rnd[0], 2'(3 - i)};
            wr(7'h01, d, old);
            old = d & 8'h1f;
            check(8'(auxSupplyMode), 8'(i));
            check(8'(mainResetThreshold), 8'(3 - i));
            check(8'(auxSupplyOn), 8'(i != 0));
        end
        wr(7'h01, old | 8'h80, old);
        check(8'(opMode), 8'h02);
        wr(7'h01, old | 8'h40, old | 8'h80);
        check(8'({opMode, cmdFailFlag}), 8'h05);
        pulse(cmdFailFlagClr);
        wr(7'h01, old ^ 8'h1f, old | 8'h80);
        check(8'({opMode, cmdFailFlag}), 8'h01);
        rd(7'h01, old);
        $display("test mode changes done");
        u_msc_host_model.gapCyc = 30;
        wr(7'h02, 8'hff, 8'h00);
        check(8'({chargePumpEnable, watchdogFailCountSelect}), 8'h03);
        check(8'(failOutPin), 8'h01);
        failPinIsFailOut = 1'b0;
        repeat (2) @(negedge clk_sys);
        check(8'(failOutPin), 8'h00);
        failureFlag = 1'b1;
        wr(7'h02, 8'h41, 8'h65);
        check(8'(failOutPin), 8'h01);
        failureFlag = 1'b0;
        failPinIsFailOut = 1'b1;
        repeat (2) @(negedge clk_sys);
        check(8'({failOutPin, chargePumpEnable}), 8'h00);
        wr(7'h02, 8'h61, 8'h41);
        check(8'(failOutPin), 8'h01);
        u_msc_host_model.gapCyc = 6;
        wr(7'h03, 8'hff, 8'h14);
        rd(7'h03, 8'hf7);
        $display("test hardware control done");
        wr(7'h01, 8'h1e, old);
        pulse(restartEnter);
        check(8'({opMode, auxSupplyMode, failOutPin}), 8'h00);
        rd(7'h01, 8'h02);
        rd(7'h02, 8'h41);
        wr(7'h01, 8'h0d, 8'h02);
        mainOvDetect = 1'b1;
        waitSig(mainOvFlag, 1'b1);
        // Request is set with the flag and lasts one cycle, so look at once
        check(8'(ovRestartReq), 8'h01);
        mainOvDetect = 1'b0;
        pulse(mainOvFlagClr);
        check(8'(mainOvFlag), 8'h00);
        pulse(overTempEvent);
        check(8'(auxSupplyMode), 8'h00);
        $display("test restart and events done");
        wr(7'h02, 8'h05, 8'h41);
        cfgLockClearable = 1'b1;
        wr(7'h01, 8'hc0, 8'h05);
        check(8'({resetOutOeN, resetOutPin}), 8'h00);
        waitSig(resetOutOeN, 1'b1);
        check(8'({chargePumpEnable, auxSupplyMode}), 8'h04);
        wr(7'h02, 8'h40, 8'h04);
        rd(7'h02, 8'h44);
        cfgLockPermanent = 1'b1;
        cfgLockClearable = 1'b0;
        wr(7'h01, 8'hc0, 8'h00);
        check(8'(resetOutOeN), 8'h01);
        rd(7'h02, 8'h40);
        rd(7'h03, 8'h14);
        $display("test soft reset done");
        results();
    end
endmodule // testbench
`default_nettype wire
